// [shared/qbio_pkg.sv]
// package of constants and carriers for the quasi-bidirectional port block
`default_nettype none
package qbio_pkg;
	localparam int                PORT_W     = 8;
	localparam int                NUM_PORTS  = 3;
	localparam logic [7:0]        LATCH_RST  = 8'hff;
	localparam logic [2:0]        FSEL_RST   = 3'h0;
	// port index on the core access bus, for byte writes, bit writes and reads
	localparam logic [1:0]        PORT_ONE   = 2'h0;
	localparam logic [1:0]        PORT_THREE = 2'h1;
	localparam logic [1:0]        PORT_FOUR  = 2'h2;

	// per-pin function select
	typedef enum logic [2:0] {
		QBIO_FN_GPIO,
		QBIO_FN_SERIAL,
		QBIO_FN_SPI,
		QBIO_FN_I2C,
		QBIO_FN_ADC,
		QBIO_FN_CA_OUT,
		QBIO_FN_CA_IN,
		QBIO_FN_TIMER_IN
	} qbio_fn_t;

	// pin driver controls, one bit per pin
	typedef struct packed {
		logic [23:0] low_drv;
		logic [23:0] high_drv;
		logic [23:0] pullup_en;
		logic [23:0] analog_en;
	} qbio_drv_t;

	// core access to the latches
	typedef struct packed {
		logic       byte_wr;
		logic       bit_wr;
		logic [1:0] port;
		logic [2:0] bit_sel;
		logic [7:0] wdata;
		logic       rmw_rd;
	} qbio_cpu_t;
endpackage : qbio_pkg
`default_nettype wire

// [core/qbio_ports.sv]
// three quasi-bidirectional 8-bit ports with per-pin function routing
// ------------------------------------------------------------
// ------------------------------------------------------------
`default_nettype none
module qbio_ports (
	input  wire logic               sys_clk,
	input  wire logic               rst,
	input  wire qbio_pkg::qbio_cpu_t cpu,
	input  wire logic [71:0]        fn_sel,
	input  wire logic               fn_wr,
	input  wire logic [23:0]        alt_out,
	input  wire logic [23:0]        pin_in,
	input  wire logic [7:0]         bus_ad_out,
	input  wire logic               bus_ad_oe,
	input  wire logic               bus_rd_n,
	input  wire logic               bus_wr_n,
	input  wire logic               bus_fetch_n,
	input  wire logic               bus_ale,
	input  wire logic [7:0]         muxed_addr_data_bus_i,
	output logic [7:0]              rdata,
	output logic [23:0]             alt_in,
	output qbio_pkg::qbio_drv_t     drv,
	output logic [7:0]              muxed_addr_data_bus_o,
	output logic                    muxed_addr_data_bus_oe,
	output logic [7:0]              bus_ad_in,
	output logic [3:0]              bus_ctl_o
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  port_one_latch;
		logic [7:0]  port_three_latch;
		logic [7:0]  port_four_latch;
		logic [71:0] fsel;
		logic [23:0] src_dly;
		logic [23:0] pin_m;
		logic [23:0] pin_s;
		logic [7:0]  bus_m;
		logic [7:0]  bus_s;
		logic [7:0]  rdata;
		logic [23:0] alt_in;
		qbio_pkg::qbio_drv_t drv;
		logic [7:0]  ad_o;
		logic        ad_oe;
		logic [7:0]  ad_in;
		logic [3:0]  ctl;
	} qbio_state_t;

	qbio_state_t st_reg;
	qbio_state_t st_next;

	// byte after a write or single-bit update of one latch
	function automatic logic [7:0] qbio_upd(
		input logic [7:0]          cur,
		input logic [1:0]          idx,
		input qbio_pkg::qbio_cpu_t c
	);
		logic [7:0] v;
		v = cur;
		if (c.port == idx) begin
			if (c.byte_wr) begin
				v = c.wdata;
			end else if (c.bit_wr) begin
				v[c.bit_sel] = c.wdata[0];
			end
		end
		return v;
	endfunction : qbio_upd

	// drive of one pin: low-side, high-side, pull-ups, analog switch
	typedef struct packed {
		logic low;
		logic high;
		logic pull;
		logic analog;
	} qbio_pin_drv_t;

	// ------------------------------------------------------------
	// pin function decode
	// ------------------------------------------------------------
	// function code of one pin out of the packed select word
	function automatic qbio_pkg::qbio_fn_t qbio_fn_of(
		input logic [71:0] sel,
		input int          pin
	);
		return qbio_pkg::qbio_fn_t'(sel[pin*3 +: 3]);
	endfunction : qbio_fn_of

	// gpio pins follow their latch, every other function its peripheral
	function automatic logic qbio_src_of(
		input qbio_pkg::qbio_fn_t f,
		input logic               latch_bit,
		input logic               alt_bit
	);
		logic s;
		s = alt_bit;
		if (f == qbio_pkg::QBIO_FN_GPIO) begin
			s = latch_bit;
		end
		return s;
	endfunction : qbio_src_of

	// driver mode fixed by the selected function
	function automatic qbio_pin_drv_t qbio_mode_drv(
		input qbio_pkg::qbio_fn_t f,
		input logic               s,
		input logic               r
	);
		qbio_pin_drv_t d;
		d = '0;
		unique case (f)
			qbio_pkg::QBIO_FN_GPIO, qbio_pkg::QBIO_FN_SERIAL,
			qbio_pkg::QBIO_FN_SPI: begin
				// quasi: strong low, one-clock kick high, weak hold
				d.low  = ~s;
				d.high = r;
				d.pull = s;
			end
			qbio_pkg::QBIO_FN_CA_OUT: begin
				d.low  = ~s;
				d.high = s;
			end
			qbio_pkg::QBIO_FN_I2C: begin
				// open drain, the bus keeps its own pull-up
				d.low = ~s;
			end
			qbio_pkg::QBIO_FN_ADC: begin
				// digital side fully off so the analog level is not loaded
				d.analog = 1'b1;
			end
			qbio_pkg::QBIO_FN_CA_IN, qbio_pkg::QBIO_FN_TIMER_IN: begin
				// quasi structure kept, pin never pulled low
				d.pull = 1'b1;
			end
		endcase
		return d;
	endfunction : qbio_mode_drv

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	// read-modify-write sees the latch, a plain read sees the pins
	function automatic logic [7:0] qbio_rd_byte(
		input logic       rmw,
		input logic [7:0] latch,
		input logic [7:0] pins
	);
		return rmw ? latch : pins;
	endfunction : qbio_rd_byte

	// ------------------------------------------------------------
	// reset image
	// ------------------------------------------------------------
	// latches all ones, every pin a gpio input
	function automatic qbio_state_t qbio_rst_image();
		qbio_state_t s;
		s                  = '0;
		s.port_one_latch   = qbio_pkg::LATCH_RST;
		s.port_three_latch = qbio_pkg::LATCH_RST;
		s.port_four_latch  = qbio_pkg::LATCH_RST;
		// delayed copy matches the latches, so no kick leaves reset
		s.src_dly          = '1;
		s.fsel             = {24{qbio_pkg::FSEL_RST}};
		s.pin_m            = '0;
		s.pin_s            = '0;
		s.bus_m            = '0;
		s.bus_s            = '0;
		s.rdata            = '0;
		s.alt_in           = '0;
		s.drv.low_drv      = '0;
		s.drv.high_drv     = '0;
		s.drv.pullup_en    = '1;
		s.drv.analog_en    = '0;
		s.ad_o             = '0;
		s.ad_oe            = 1'b0;
		s.ad_in            = '0;
		// bus strobes idle high, address latch idle low
		s.ctl              = 4'h7;
		return s;
	endfunction : qbio_rst_image

	logic [23:0] latch_all;
	logic [23:0] src;
	logic [23:0] rise;
	qbio_pkg::qbio_fn_t fn;
	qbio_pin_drv_t      pdv;

	always_comb begin
		st_next = st_reg;
		fn = qbio_pkg::QBIO_FN_GPIO;
		pdv = '0;
		// ------------------------------------------------------------
		// latches and function selects
		// ------------------------------------------------------------
		st_next.port_one_latch   = qbio_upd(st_reg.port_one_latch, qbio_pkg::PORT_ONE, cpu);
		st_next.port_three_latch = qbio_upd(st_reg.port_three_latch, qbio_pkg::PORT_THREE, cpu);
		st_next.port_four_latch  = qbio_upd(st_reg.port_four_latch, qbio_pkg::PORT_FOUR, cpu);
		if (fn_wr) begin
			st_next.fsel = fn_sel;
		end
		// pins pass two flops before any logic looks at them
		st_next.pin_m = pin_in;
		st_next.pin_s = st_reg.pin_m;
		st_next.bus_m = muxed_addr_data_bus_i;
		st_next.bus_s = st_reg.bus_m;
		// ------------------------------------------------------------
		// driver source per pin: latch for gpio, peripheral otherwise
		// ------------------------------------------------------------
		latch_all = {st_reg.port_four_latch, st_reg.port_three_latch, st_reg.port_one_latch};
		for (int i = 0; i < 24; i++) begin
			fn     = qbio_fn_of(st_reg.fsel, i);
			src[i] = qbio_src_of(fn, latch_all[i], alt_out[i]);
		end
		st_next.src_dly = src;
		rise = src & ~st_reg.src_dly;
		// ------------------------------------------------------------
		// pin drivers
		// ------------------------------------------------------------
		for (int i = 0; i < 24; i++) begin
			fn  = qbio_fn_of(st_reg.fsel, i);
			pdv = qbio_mode_drv(fn, src[i], rise[i]);
			st_next.drv.low_drv[i]   = pdv.low;
			st_next.drv.high_drv[i]  = pdv.high;
			st_next.drv.pullup_en[i] = pdv.pull;
			st_next.drv.analog_en[i] = pdv.analog;
		end
		st_next.alt_in = st_reg.pin_s;
		// ------------------------------------------------------------
		// core read path
		// ------------------------------------------------------------
		unique case (cpu.port)
			qbio_pkg::PORT_ONE: begin
				st_next.rdata = qbio_rd_byte(cpu.rmw_rd, st_reg.port_one_latch,
					st_reg.pin_s[7:0]);
			end
			qbio_pkg::PORT_THREE: begin
				st_next.rdata = qbio_rd_byte(cpu.rmw_rd, st_reg.port_three_latch,
					st_reg.pin_s[15:8]);
			end
			qbio_pkg::PORT_FOUR: begin
				st_next.rdata = qbio_rd_byte(cpu.rmw_rd, st_reg.port_four_latch,
					st_reg.pin_s[23:16]);
			end
			default: begin
				st_next.rdata = 8'h00;
			end
		endcase
		// ------------------------------------------------------------
		// dedicated bus ports; no gpio path, low address byte only
		// ------------------------------------------------------------
		st_next.ad_o  = bus_ad_out;
		st_next.ad_oe = bus_ad_oe;
		st_next.ad_in = st_reg.bus_s;
		st_next.ctl   = {bus_ale, bus_fetch_n, bus_wr_n, bus_rd_n};
		// ------------------------------------------------------------
		// reset
		// ------------------------------------------------------------
		if (rst) begin
			st_next = qbio_rst_image();
		end
	end

	always_ff @(posedge sys_clk) begin
		st_reg <= st_next;
	end

	// ------------------------------------------------------------
	// outputs, all straight from flops
	// ------------------------------------------------------------
	assign rdata                  = st_reg.rdata;
	assign alt_in                 = st_reg.alt_in;
	assign drv                    = st_reg.drv;
	assign muxed_addr_data_bus_o  = st_reg.ad_o;
	assign muxed_addr_data_bus_oe = st_reg.ad_oe;
	assign bus_ad_in              = st_reg.ad_in;
	assign bus_ctl_o              = st_reg.ctl;
endmodule : qbio_ports
`default_nettype wire

// [bench/qbio_ports_assertions.sv]
// checker on the port block pins
`default_nettype none
module qbio_chk (
	input wire logic                sys_clk,
	input wire logic                rst,
	input wire qbio_pkg::qbio_cpu_t cpu,
	input wire logic [71:0]         fn_sel,
	input wire logic                fn_wr,
	input wire qbio_pkg::qbio_drv_t drv
);
	// --
	// pin 0 select, last five cycles
	// --
	logic [14:0] fh_reg;
	logic        w0;
	assign w0 = cpu.port == 2'h0 && (cpu.byte_wr || cpu.bit_wr && cpu.bit_sel == 3'h0);
	// judge a pin only once its select has settled
	always_ff @(posedge sys_clk)
		fh_reg <= rst ? 15'h0 : {fh_reg[11:0], fn_wr ? fn_sel[2:0] : fh_reg[2:0]};
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_wr(b);
		w0 && cpu.wdata[0] == b;
	endsequence
	sequence s_rise;
		s_wr(1'b0) ##1 s_wr(1'b1);
	endsequence
	a_reset_state: assert property ($past(rst) |-> drv.pullup_en == 24'hffffff
		&& (drv.low_drv | drv.high_drv | drv.analog_en) == 24'h0) else $error("reset state");
	a_drive_excl: assert property ((drv.low_drv & drv.high_drv) == 24'h0)
		else $error("both drivers");
	a_zero_drive: assert property (s_wr(1'b0) ##2 fh_reg == 15'h0 |-> drv.low_drv[0]
		&& !drv.high_drv[0] && !drv.pullup_en[0]) else $error("zero drive");
	a_rise_pulse: assert property (s_rise ##1 !w0 ##2 fh_reg == 15'h0 |->
		$past(drv.high_drv[0]) && !drv.high_drv[0] && drv.pullup_en[0]) else $error("pulse");
	a_no_repulse: assert property (s_wr(1'b1) ##1 s_wr(1'b1) ##2 fh_reg == 15'h0 |->
		!drv.high_drv[0]) else $error("repulse");
	a_adc_quiet: assert property (fh_reg == {5{3'h4}} |-> drv.analog_en[0]
		&& !drv.low_drv[0] && !drv.high_drv[0]) else $error("adc driven");
	a_i2c_nohigh: assert property (fh_reg == {5{3'h3}} |-> !drv.high_drv[0])
		else $error("i2c high");
	a_tin_nodrive: assert property (fh_reg == {5{3'h7}} |->
		!(drv.low_drv[0] || drv.high_drv[0] || drv.analog_en[0])) else $error("input driven");
endmodule : qbio_chk
bind qbio_ports qbio_chk i_qbio_chk (.sys_clk(sys_clk), .rst(rst), .cpu(cpu),
	.fn_sel(fn_sel), .fn_wr(fn_wr), .drv(drv));
`default_nettype wire

// [bench/qbio_pin_model.sv]
// external devices on the port pins
`default_nettype none
module qbio_pin_model (
	input  wire logic                sys_clk,
	input  wire qbio_pkg::qbio_drv_t drv,
	input  wire logic [23:0]         ext_en,
	input  wire logic [23:0]         ext_val,
	output logic [23:0]              pin_lvl
);
	logic [23:0] last_reg;
	// an unheld pin wanders, so a stale level never passes
	assign pin_lvl = ~drv.low_drv & (ext_en & ext_val | ~ext_en & (drv.high_drv
		| drv.pullup_en | ~last_reg));
	always_ff @(posedge sys_clk)
		last_reg <= pin_lvl;
endmodule : qbio_pin_model
`default_nettype wire

// [bench/qbio_ports_tb_top.sv]
// self-checking bench for the port block
`default_nettype none
module qbio_ports_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                sys_clk = 1'b0, rst = 1'b1, fn_wr = 1'b0, ad_oe;
	qbio_pkg::qbio_cpu_t cpu = '0;
	qbio_pkg::qbio_drv_t drv;
	logic [71:0]         fn_sel = '0;
	logic [23:0]         alt_out = '0, ext_en = '0, ext_val = '0, pins, p1v;
	logic [7:0]          rdata, bus_v = '0, ad_o, ad_i;
	logic [3:0]          ctl;
	int                  fails = 0, num_checks = 0, cyc = 0;
	assign p1v = {drv.pullup_en[7:0], drv.low_drv[7:0], drv.high_drv[7:0]};
	always #2 sys_clk = ~sys_clk;
	qbio_ports i_qbio_ports (.sys_clk(sys_clk), .rst(rst), .cpu(cpu), .fn_sel(fn_sel),
		.fn_wr(fn_wr), .alt_out(alt_out), .pin_in(pins), .bus_ad_out(bus_v),
		.bus_ad_oe(bus_v[4]), .bus_rd_n(bus_v[0]), .bus_wr_n(bus_v[1]), .bus_fetch_n(bus_v[2]),
		.bus_ale(bus_v[3]), .muxed_addr_data_bus_i(bus_v), .rdata(rdata), .alt_in(),
		.drv(drv), .muxed_addr_data_bus_o(ad_o), .muxed_addr_data_bus_oe(ad_oe),
		.bus_ad_in(ad_i), .bus_ctl_o(ctl));
	qbio_pin_model i_qbio_pin_model (.sys_clk(sys_clk), .drv(drv), .ext_en(ext_en),
		.ext_val(ext_val), .pin_lvl(pins));
	task automatic tick(int n);
		repeat (n) @(negedge sys_clk);
	endtask : tick
	task automatic chk(string n, logic [23:0] e, logic [23:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// strobes stay up until the next access, so no double drive at one edge
	task automatic wr(logic [1:0] p, logic bw, logic [2:0] b, logic [7:0] d);
		cpu = '{!bw, bw, p, b, d, 1'b0};
		tick(1);
	endtask : wr
	task automatic rd(logic [1:0] p, logic rmw, logic [7:0] e);
		cpu = '{1'b0, 1'b0, p, 3'h0, 8'h0, rmw};
		tick(1);
		chk("rdata", 24'(e), 24'(rdata));
	endtask : rd
	task automatic fn(int pin, logic [2:0] c);
		fn_sel[3*pin +: 3] = c;
		fn_wr = 1'b1;
		tick(1);
		fn_wr = 1'b0;
		tick(5);
	endtask : fn
	task automatic results();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results
	always @(posedge sys_clk)
		if (++cyc == 1000) begin
			fails++;
			results();
		end
	initial begin
		tick(10);
		rst = 1'b0;
		tick(1);
		for (int p = 0; p < 3; p++) begin
			rd(2'(p), 1'b1, 8'hff);
			rd(2'(p), 1'b0, 8'hff);
		end
		wr(2'h0, 1'b0, 3'h0, 8'h00);
		tick(1);
		chk("port one", 24'h00ff00, p1v);
		wr(2'h0, 1'b0, 3'h0, 8'hff);
		rd(2'h0, 1'b1, 8'hff);
		chk("port one", 24'hff00ff, p1v);
		tick(1);
		chk("port one", 24'hff0000, p1v);
		wr(2'h0, 1'b0, 3'h0, 8'hff);
		wr(2'h0, 1'b0, 3'h0, 8'hff);
		chk("port one", 24'hff0000, p1v);
		ext_en = 24'h000008;
		tick(4);
		rd(2'h0, 1'b1, 8'hff);
		rd(2'h0, 1'b0, 8'hf7);
		wr(2'h0, 1'b1, 3'h2, 8'h00);
		rd(2'h0, 1'b1, 8'hfb);
		ext_en = 24'h000004;
		ext_val = 24'h000004;
		tick(4);
		rd(2'h0, 1'b0, 8'hfb);
		wr(2'h0, 1'b1, 3'h2, 8'h01);
		wr(2'h2, 1'b0, 3'h0, 8'h5a);
		rd(2'h2, 1'b1, 8'h5a);
		rd(2'h0, 1'b1, 8'hff);
		fn(9, 3'h4);
		fn(0, 3'h4);
		chk("analog", 24'h000201, drv.analog_en);
		fn(0, 3'h3);
		fn(0, 3'h7);
		alt_out = 24'h000001;
		fn(0, 3'h5);
		chk("high", 24'h000001, drv.high_drv);
		alt_out = 24'h000100;
		fn(8, 3'h1);
		chk("low", 24'ha50001, drv.low_drv);
		rst = 1'b1;
		tick(10);
		rst = 1'b0;
		tick(1);
		chk("analog", 24'h0, drv.analog_en);
		bus_v = 8'h5a;
		tick(4);
		chk("bus", {3'h0, 8'h5a, 8'h5a, 1'h1, 4'ha}, {3'h0, ad_i, ad_o, ad_oe, ctl});
		results();
	end
endmodule : qbio_ports_tb_top
`default_nettype wire
